// [logic/rwc_pkg.sv]
// constants and types for reset and wake-up sequencing
package rwc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned OST_MS = 18;
  localparam int unsigned OST_CYCLES = OST_MS * (CLK_HZ / 1000);
  localparam int unsigned RC_WAKE_CYCLES = 34;
  localparam int unsigned HXT_WAKE_MS = 2;
  localparam int unsigned HXT_WAKE_EXTRA = 32;
  localparam int unsigned HXT_WAKE_CYCLES = HXT_WAKE_MS * (CLK_HZ / 1000) + HXT_WAKE_EXTRA;
  localparam int unsigned LXT2_WAKE_MS = 500;
  localparam int unsigned LXT2_WAKE_CYCLES = LXT2_WAKE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 24;
  localparam int PC_W = 10;
  // interrupt vectors per source
  localparam logic [9:0] VEC_EXT = 10'h003;
  localparam logic [9:0] VEC_PIN = 10'h006;
  localparam logic [9:0] VEC_TICK = 10'h009;
  localparam logic [9:0] VEC_CMP = 10'h00f;
  localparam logic [9:0] VEC_ADC = 10'h015;
  localparam logic [9:0] VEC_AUX2 = 10'h030;
  localparam logic [9:0] VEC_AUX3 = 10'h033;
  localparam logic [9:0] PC_RESET = 10'h000;
  // status register fields
  localparam int ST_TIMEOUT = 4;
  localparam int ST_PWRDN = 3;
  localparam logic [7:0] ST_RESET = 8'h18;
  localparam int TCFG_PIN_BIT = 6;
  localparam logic [2:0] SYNC_RESET = 3'h1;
  typedef enum logic [1:0] {OSC_RC = 2'h0, OSC_HXT = 2'h1, OSC_LXT2 = 2'h2, OSC_LXT1 = 2'h3}
    rwc_osc_t;
  typedef enum logic [1:0] {S_RESET = 2'h0, S_RUN = 2'h1, S_SLEEP = 2'h3, S_WAKE = 2'h2}
    rwc_state_t;
  // msb to lsb: aux3, aux2, comparator, adc, ext pin, pin change, tick
  typedef struct packed {
    logic aux_three;
    logic aux_two;
    logic comparator;
    logic adc_done;
    logic ext_pin;
    logic pin_change;
    logic tick_ovf;
  } rwc_events_t;
  typedef struct packed {
    logic ext_pin_wake_enable;
    logic pin_change_wake_enable;
    logic adc_done_wake_enable;
    logic comparator_wake_enable;
  } rwc_wake_en_t;
endpackage

// [logic/rwc_reset_wake.sv]
// reset gathering, start-up hold, sleep entry and wake-up sequencing
`timescale 1ns/1ps
module rwc_reset_wake #(
  parameter int unsigned OST_CYCLES = rwc_pkg::OST_CYCLES,
  parameter int unsigned HXT_WAKE_CYCLES = rwc_pkg::HXT_WAKE_CYCLES,
  parameter int unsigned LXT2_WAKE_CYCLES = rwc_pkg::LXT2_WAKE_CYCLES
) (
  // clock and power-on reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // pins
  input  wire logic                       reset_pin_n,
  input  wire logic                       wdt_timeout,
  input  wire logic                       ext_int_pin,
  // configuration
  input  wire logic                       wdt_enable,
  input  wire rwc_pkg::rwc_osc_t          osc_mode,
  input  wire logic                       idle_select,
  input  wire rwc_pkg::rwc_wake_en_t      wake_en,
  input  wire logic [1:0]                 aux_irq_enable,
  // core instructions and events
  input  wire logic                       sleep_instr,
  input  wire logic                       global_irq_on_instr,
  input  wire logic                       global_irq_off_instr,
  input  wire rwc_pkg::rwc_events_t       events,
  // register writes
  input  wire logic                       status_wr,
  input  wire logic                       timer_config_wr,
  input  wire logic                       int_flag_wr,
  input  wire logic                       int_mask_wr,
  input  wire logic                       bank_wr,
  input  wire logic [1:0]                 bank_sel,
  input  wire logic [7:0]                 wr_data,
  // core control
  output logic                            core_reset,
  output logic                            pc_load,
  output logic [rwc_pkg::PC_W-1:0]        pc_value,
  output logic                            irq_take,
  output logic                            resume_next,
  output logic                            halted,
  output logic                            wdt_clear,
  output logic                            ports_input,
  output logic                            main_clock_on,
  output logic                            slow_clock_on,
  // registers
  output logic [7:0]                      status_reg,
  output logic [7:0]                      timer_config_reg,
  output logic [7:0]                      int_flag_reg,
  output logic [7:0]                      int_mask_reg,
  output logic [31:0]                     bank_regs
);
  localparam logic [rwc_pkg::CNT_W-1:0] OST_LAST = rwc_pkg::CNT_W'(OST_CYCLES - 1);

  rwc_pkg::rwc_state_t state, next_state;
  logic [rwc_pkg::CNT_W-1:0] cnt, next_cnt, wake_last;
  logic [2:0] sync1, sync2;
  logic pin_low, wdt_hit, rst_req, gie, wdt_at_sleep, idle_mode, wake_req;
  logic [6:0] en_vec, src, wake_src;
  logic [rwc_pkg::PC_W-1:0] vec;

  // pins cross in through two flops; bit 0 idles high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= rwc_pkg::SYNC_RESET;
      sync2 <= rwc_pkg::SYNC_RESET;
    end else begin
      sync1 <= {ext_int_pin, wdt_timeout, reset_pin_n};
      sync2 <= sync1;
    end
  end

  assign pin_low = !sync2[0];
  assign wdt_hit = sync2[1] && wdt_enable;
  assign rst_req = pin_low || wdt_hit;
  assign en_vec = {aux_irq_enable, int_mask_reg[7], int_mask_reg[6], int_mask_reg[2:0]};

  // enabled wake events; timers count only in idle
  always_comb begin
    wake_req = 1'b0;
    if (!wdt_at_sleep) begin
      wake_req = (events.ext_pin && wake_en.ext_pin_wake_enable) ||
                 (events.pin_change && wake_en.pin_change_wake_enable) ||
                 (events.adc_done && wake_en.adc_done_wake_enable) ||
                 (events.comparator && wake_en.comparator_wake_enable);
    end
    if (idle_mode && (events.tick_ovf || events.aux_two || events.aux_three)) begin
      wake_req = 1'b1;
    end
  end

  always_comb begin
    case (osc_mode)
      rwc_pkg::OSC_HXT:  wake_last = rwc_pkg::CNT_W'(HXT_WAKE_CYCLES - 1);
      rwc_pkg::OSC_LXT2: wake_last = rwc_pkg::CNT_W'(LXT2_WAKE_CYCLES - 1);
      default:           wake_last = rwc_pkg::CNT_W'(rwc_pkg::RC_WAKE_CYCLES - 1);
    endcase
  end

  // source for the vector: captured at wake, live while running
  assign src = (state == rwc_pkg::S_WAKE) ? wake_src : (events & en_vec);
  always_comb begin
    if (src[2])      vec = rwc_pkg::VEC_EXT;
    else if (src[1]) vec = rwc_pkg::VEC_PIN;
    else if (src[0]) vec = rwc_pkg::VEC_TICK;
    else if (src[4]) vec = rwc_pkg::VEC_CMP;
    else if (src[3]) vec = rwc_pkg::VEC_ADC;
    else if (src[5]) vec = rwc_pkg::VEC_AUX2;
    else             vec = rwc_pkg::VEC_AUX3;
  end

  always_comb begin
    next_state = state;
    next_cnt = '0;
    if (rst_req) begin
      next_state = rwc_pkg::S_RESET;
    end else begin
      case (state)
        rwc_pkg::S_RESET: begin
          if (cnt == OST_LAST) next_state = rwc_pkg::S_RUN;
          else next_cnt = cnt + 1'b1;
        end
        rwc_pkg::S_RUN: if (sleep_instr) next_state = rwc_pkg::S_SLEEP;
        rwc_pkg::S_SLEEP: if (wake_req) next_state = rwc_pkg::S_WAKE;
        rwc_pkg::S_WAKE: begin
          if (cnt >= wake_last) next_state = rwc_pkg::S_RUN;
          else next_cnt = cnt + 1'b1;
        end
        default: next_state = rwc_pkg::S_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= rwc_pkg::S_RESET;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // sleep context
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gie <= 1'b0;
      wdt_at_sleep <= 1'b0;
      idle_mode <= 1'b0;
      wake_src <= '0;
    end else begin
      if (next_state == rwc_pkg::S_RESET) gie <= 1'b0;
      else if (global_irq_on_instr) gie <= 1'b1;
      else if (global_irq_off_instr) gie <= 1'b0;
      if (state == rwc_pkg::S_RUN && sleep_instr) begin
        wdt_at_sleep <= wdt_enable;
        idle_mode <= idle_select;
      end
      if (state == rwc_pkg::S_SLEEP && wake_req) wake_src <= events;
    end
  end

  // core control outputs, registered from the next state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_reset <= 1'b1;
      pc_load <= 1'b0;
      pc_value <= rwc_pkg::PC_RESET;
      irq_take <= 1'b0;
      resume_next <= 1'b0;
      halted <= 1'b0;
      wdt_clear <= 1'b1;
      ports_input <= 1'b1;
      main_clock_on <= 1'b1;
      slow_clock_on <= 1'b1;
    end else begin
      core_reset <= next_state == rwc_pkg::S_RESET;
      ports_input <= next_state == rwc_pkg::S_RESET;
      halted <= next_state == rwc_pkg::S_SLEEP || next_state == rwc_pkg::S_WAKE;
      // watchdog counting itself lives in its own domain; only cleared here
      wdt_clear <= next_state == rwc_pkg::S_RESET ||
                   (state == rwc_pkg::S_RUN && sleep_instr && wdt_enable);
      pc_load <= 1'b0;
      irq_take <= 1'b0;
      resume_next <= 1'b0;
      if (next_state == rwc_pkg::S_RESET) begin
        pc_value <= rwc_pkg::PC_RESET;
      end else if (state == rwc_pkg::S_RESET) begin
        pc_load <= 1'b1;
      end else if (state == rwc_pkg::S_WAKE && next_state == rwc_pkg::S_RUN) begin
        if (gie) begin
          pc_load <= 1'b1;
          irq_take <= 1'b1;
          pc_value <= vec;
        end else begin
          resume_next <= 1'b1;
        end
      end else if (state == rwc_pkg::S_RUN && !sleep_instr && gie && |(events & en_vec)) begin
        pc_load <= 1'b1;
        irq_take <= 1'b1;
        pc_value <= vec;
      end
      // oscillator runs through reset; adc wake holds both clocks
      main_clock_on <= !(next_state == rwc_pkg::S_SLEEP) ||
                       wake_en.adc_done_wake_enable;
      slow_clock_on <= !(next_state == rwc_pkg::S_SLEEP && !idle_mode) ||
                       wake_en.adc_done_wake_enable;
    end
  end

  // status: top bits only cleared by power-on, writes blocked in reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= rwc_pkg::ST_RESET;
    end else if (rst_req && state != rwc_pkg::S_RESET) begin
      status_reg[rwc_pkg::ST_TIMEOUT] <= !wdt_hit || pin_low;
      status_reg[rwc_pkg::ST_PWRDN] <= state == rwc_pkg::S_RUN;
    end else if (state == rwc_pkg::S_RUN && sleep_instr) begin
      status_reg[rwc_pkg::ST_TIMEOUT] <= 1'b1;
      status_reg[rwc_pkg::ST_PWRDN] <= 1'b0;
    end else if (status_wr && !core_reset) begin
      status_reg[7:5] <= wr_data[7:5];
      status_reg[2:0] <= wr_data[2:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_config_reg <= '0;
    end else begin
      if (core_reset) timer_config_reg <= '0;
      else if (timer_config_wr) timer_config_reg <= wr_data;
      timer_config_reg[rwc_pkg::TCFG_PIN_BIT] <= sync2[2];
    end
  end

  // flags: an event in the clearing cycle still sets its bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_flag_reg <= '0;
      int_mask_reg <= '0;
    end else if (core_reset) begin
      int_flag_reg <= '0;
      int_mask_reg <= '0;
    end else begin
      int_flag_reg <= (int_flag_wr ? wr_data : int_flag_reg) |
                      {events.comparator, events.adc_done, 3'h0,
                       events.ext_pin, events.pin_change, events.tick_ovf};
      if (int_mask_wr) int_mask_reg <= wr_data;
    end
  end

  // bank registers clear only with power-on reset
  for (genvar i = 0; i < 4; i++) begin : g_bank
    always_ff @(posedge clk or posedge reset) begin
      if (reset) bank_regs[i*8 +: 8] <= '0;
      else if (bank_wr && bank_sel == 2'(i)) bank_regs[i*8 +: 8] <= wr_data;
    end
  end

  // checks
  logic [rwc_pkg::CNT_W-1:0] rst_len, wake_len;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rst_len <= '0;
    else rst_len <= core_reset ? rst_len + 1'b1 : '0;
  end

  // length of the wake delay, counted apart from the state counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) wake_len <= '0;
    else wake_len <= (state == rwc_pkg::S_WAKE) ? wake_len + 1'b1 : '0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  rst_hold_a: assert property ($fell(core_reset) |-> rst_len >= OST_LAST)
    else $error("reset released early");
  rst_entry_a: assert property (rst_req |=> ##1 core_reset && pc_value == '0)
    else $error("reset source missed");
  pc_zero_a: assert property ($fell(core_reset) |-> pc_load && pc_value == '0)
    else $error("bad start address");
  port_input_a: assert property (core_reset |-> ports_input && wdt_clear)
    else $error("ports or watchdog not reset");
  status_keep_a: assert property (
    core_reset && $past(core_reset) |=> $stable(status_reg[7:5]))
    else $error("status top bits changed");
  cfg_clear_a: assert property (
    core_reset ##1 core_reset |-> (timer_config_reg & 8'hbf) == 8'h00)
    else $error("timer config not cleared");
  irq_clear_a: assert property (
    core_reset |=> int_mask_reg == 8'h00 && int_flag_reg == 8'h00)
    else $error("interrupt regs not cleared");
  sleep_wdt_a: assert property (
    state == rwc_pkg::S_RUN && sleep_instr && wdt_enable && !rst_req |=> wdt_clear)
    else $error("watchdog not cleared at sleep");
  rc_wake_a: assert property (
    state == rwc_pkg::S_WAKE && osc_mode == rwc_pkg::OSC_RC ##1 state == rwc_pkg::S_RUN
    |-> wake_len == rwc_pkg::CNT_W'(rwc_pkg::RC_WAKE_CYCLES))
    else $error("rc wake time wrong");
  wdt_mask_a: assert property (
    state == rwc_pkg::S_SLEEP && wdt_at_sleep && !idle_mode |=> state != rwc_pkg::S_WAKE)
    else $error("wake enable honoured under watchdog");
  resume_a: assert property (
    state == rwc_pkg::S_WAKE && next_state == rwc_pkg::S_RUN
    |=> (irq_take == gie && resume_next == !gie))
    else $error("wrong resume kind");
  adc_clk_a: assert property (
    halted && wake_en.adc_done_wake_enable && $past(wake_en.adc_done_wake_enable)
    |-> main_clock_on && slow_clock_on)
    else $error("clocks stopped with adc wake");

  sleep_wake_c: cover property (state == rwc_pkg::S_SLEEP ##1 state == rwc_pkg::S_WAKE);
  wake_irq_c: cover property (halted ##1 irq_take);
  wdt_reset_c: cover property (wdt_hit && state == rwc_pkg::S_SLEEP);
endmodule

// [bench/rwc_core_model.sv]
// processor core model: issues sleep and global interrupt on/off instructions
`timescale 1ns/1ps
module rwc_core_model (
  // clock and core state
  input  wire logic clk,
  input  wire logic core_reset,
  input  wire logic halted,
  // instruction pulses
  output logic      sleep_instr,
  output logic      global_irq_on_instr,
  output logic      global_irq_off_instr
);
  initial begin
    sleep_instr = 1'b0;
    global_irq_on_instr = 1'b0;
    global_irq_off_instr = 1'b0;
  end

  // a halted or held core executes nothing, so no sleep is issued then
  task automatic pulse_sleep();
    @(negedge clk);
    if (!core_reset && !halted) begin
      sleep_instr = 1'b1;
      @(negedge clk);
      sleep_instr = 1'b0;
    end
  endtask

  // software sets or clears gie before sleeping, ahead of setting the wake enables
  task automatic set_gie(input logic on);
    @(negedge clk);
    global_irq_on_instr = on;
    global_irq_off_instr = !on;
    @(negedge clk);
    global_irq_on_instr = 1'b0;
    global_irq_off_instr = 1'b0;
  endtask
endmodule

// [bench/reset_and_wakeup_control_tb.sv]
// testbench for reset and wake-up sequencing
`timescale 1ns/1ps
module reset_and_wakeup_control_tb;
  // shortened counts keep the run small
  localparam int OST = 20;
  localparam int HXT = 10;
  localparam int LXT2 = 20;
  localparam int DLY_T [4] = '{34, HXT, LXT2, 34};
  localparam logic [6:0] EV_T [4] = '{7'h04, 7'h02, 7'h10, 7'h08};
  localparam logic [3:0] WE_T [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
  localparam logic [9:0] VEC_T [4] = '{10'h003, 10'h006, 10'h00f, 10'h015};
  localparam logic [6:0] IEV_T [3] = '{7'h01, 7'h20, 7'h40};
  localparam logic [9:0] IVEC_T [3] = '{10'h009, 10'h030, 10'h033};

  logic                  clk, reset, reset_pin_n, wdt_timeout, ext_int_pin;
  logic                  wdt_enable, idle_select, sleep_instr;
  logic                  global_irq_on_instr, global_irq_off_instr;
  logic                  status_wr, timer_config_wr, int_flag_wr, int_mask_wr, bank_wr;
  logic                  core_reset, pc_load, irq_take, resume_next, halted;
  logic                  wdt_clear, ports_input, main_clock_on, slow_clock_on;
  logic [1:0]            aux_irq_enable, bank_sel;
  logic [7:0]            wr_data, status_reg, timer_config_reg, int_flag_reg, int_mask_reg;
  logic [9:0]            pc_value;
  logic [31:0]           bank_regs;
  rwc_pkg::rwc_osc_t     osc_mode;
  rwc_pkg::rwc_wake_en_t wake_en;
  rwc_pkg::rwc_events_t  events;
  int                    mismatches = 0;
  int                    compares = 0;

  rwc_reset_wake #(
    .OST_CYCLES       (OST),
    .HXT_WAKE_CYCLES  (HXT),
    .LXT2_WAKE_CYCLES (LXT2)
  ) uut (
    .clk                  (clk),
    .reset                (reset),
    .reset_pin_n          (reset_pin_n),
    .wdt_timeout          (wdt_timeout),
    .ext_int_pin          (ext_int_pin),
    .wdt_enable           (wdt_enable),
    .osc_mode             (osc_mode),
    .idle_select          (idle_select),
    .wake_en              (wake_en),
    .aux_irq_enable       (aux_irq_enable),
    .sleep_instr          (sleep_instr),
    .global_irq_on_instr  (global_irq_on_instr),
    .global_irq_off_instr (global_irq_off_instr),
    .events               (events),
    .status_wr            (status_wr),
    .timer_config_wr      (timer_config_wr),
    .int_flag_wr          (int_flag_wr),
    .int_mask_wr          (int_mask_wr),
    .bank_wr              (bank_wr),
    .bank_sel             (bank_sel),
    .wr_data              (wr_data),
    .core_reset           (core_reset),
    .pc_load              (pc_load),
    .pc_value             (pc_value),
    .irq_take             (irq_take),
    .resume_next          (resume_next),
    .halted               (halted),
    .wdt_clear            (wdt_clear),
    .ports_input          (ports_input),
    .main_clock_on        (main_clock_on),
    .slow_clock_on        (slow_clock_on),
    .status_reg           (status_reg),
    .timer_config_reg     (timer_config_reg),
    .int_flag_reg         (int_flag_reg),
    .int_mask_reg         (int_mask_reg),
    .bank_regs            (bank_regs)
  );

  rwc_core_model core (
    .clk                  (clk),
    .core_reset           (core_reset),
    .halted               (halted),
    .sleep_instr          (sleep_instr),
    .global_irq_on_instr  (global_irq_on_instr),
    .global_irq_off_instr (global_irq_off_instr)
  );

  always #20 clk = ~clk;

  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    compares++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("unexpected at %0t: delay %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask

  // sel 0 status, 1 timer config, 2 flags, 3 mask, 4..7 bank entries
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk);
    wr_data = d;
    bank_sel = sel[1:0];
    status_wr = sel == 0;
    timer_config_wr = sel == 1;
    int_flag_wr = sel == 2;
    int_mask_wr = sel == 3;
    bank_wr = sel >= 4;
    @(negedge clk);
    {status_wr, timer_config_wr, int_flag_wr, int_mask_wr, bank_wr} = '0;
  endtask

  task automatic ev(input rwc_pkg::rwc_events_t e);
    @(negedge clk);
    events = e;
    @(negedge clk);
    events = '0;
  endtask

  task automatic wait_out(input int bound, output int n);
    n = 0;
    while (pc_load !== 1'b1 && resume_next !== 1'b1) begin
      if (n == bound) begin
        mismatches++;
        $display("unexpected at %0t: core never resumed", $time);
        stop_test();
      end
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_rst(input logic lvl, input int bound, output int n);
    n = 0;
    while (core_reset !== lvl) begin
      if (n == bound) begin
        mismatches++;
        $display("unexpected at %0t: core reset stuck", $time);
        stop_test();
      end
      @(negedge clk);
      n++;
    end
  endtask

  task automatic quiet(input int cycles);
    int hits;
    hits = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (pc_load !== 1'b0 || resume_next !== 1'b0) hits++;
    end
    chk(hits, 0);
  endtask

  // src 0 pulls the reset pin, otherwise the watchdog times out
  task automatic do_reset(input int src);
    int n;
    @(negedge clk);
    if (src == 0) reset_pin_n = 1'b0;
    else wdt_timeout = 1'b1;
    wait_rst(1'b1, 20, n);
    chk(ports_input, 1'b1);
    chk(wdt_clear, 1'b1);
    reset_pin_n = 1'b1;
    wdt_timeout = 1'b0;
    wait_rst(1'b0, OST + 40, n);
    chk_rng(n, OST, OST + 4);
    chk({pc_load, pc_value}, 11'h400);
  endtask

  task automatic go_sleep(output logic seen_clear);
    core.pulse_sleep();
    seen_clear = wdt_clear;
    @(negedge clk);
    seen_clear |= wdt_clear;
    chk(halted, 1'b1);
  endtask

  initial begin
    int n;
    logic wc;
    clk = 1'b0;
    reset = 1'b1;
    reset_pin_n = 1'b1;
    {wdt_timeout, ext_int_pin, wdt_enable, idle_select} = '0;
    {status_wr, timer_config_wr, int_flag_wr, int_mask_wr, bank_wr} = '0;
    aux_irq_enable = 2'h3;
    bank_sel = 2'h0;
    wr_data = 8'h00;
    osc_mode = rwc_pkg::OSC_RC;
    wake_en = '0;
    events = '0;
    repeat (16) @(negedge clk);
    chk({core_reset, ports_input, wdt_clear, main_clock_on}, 4'hf);
    chk({status_reg, pc_value}, {8'h18, 10'h000});
    chk({timer_config_reg, int_flag_reg, int_mask_reg}, 24'h0);
    reset = 1'b0;
    wait_rst(1'b0, OST + 40, n);
    chk_rng(n, OST, OST + 3);
    chk({pc_load, pc_value}, 11'h400);
    wr(0, 8'he0);
    wr(1, 8'hbf);
    wr(2, 8'h01);
    wr(3, 8'hc7);
    for (int i = 4; i < 8; i++) wr(i, 8'ha0 + 8'(i));
    chk({status_reg, timer_config_reg, int_flag_reg, int_mask_reg}, 32'hf8bf01c7);
    ext_int_pin = 1'b1;
    do_reset(0);
    chk(status_reg[7:3], 5'h1f);
    chk(bank_regs, 32'ha7a6a5a4);
    chk(timer_config_reg, 8'h40);
    chk({int_flag_reg, int_mask_reg}, 16'h0);
    ext_int_pin = 1'b0;
    // a time-out with the watchdog off must not reset
    wdt_timeout = 1'b1;
    quiet(20);
    chk(core_reset, 1'b0);
    wdt_timeout = 1'b0;
    // let the released time-out pass the synchroniser before enabling
    repeat (3) @(negedge clk);
    wdt_enable = 1'b1;
    do_reset(1);
    chk(status_reg[4:3], 2'b01);
    wdt_enable = 1'b0;
    core.set_gie(1'b1);
    wr(3, 8'hc7);
    for (int i = 0; i < 4; i++) begin
      wake_en = WE_T[i];
      go_sleep(wc);
      chk(main_clock_on, i == 3);
      ev(EV_T[i]);
      wait_out(100, n);
      chk_rng(n, 34, 37);
      chk({irq_take, halted, pc_value}, {2'b10, VEC_T[i]});
      wr(2, 8'h00);
    end
    core.set_gie(1'b0);
    wake_en = 4'h8;
    for (int m = 0; m < 4; m++) begin
      osc_mode = rwc_pkg::rwc_osc_t'(m);
      go_sleep(wc);
      ev(7'h04);
      wait_out(100, n);
      chk_rng(n, DLY_T[m], DLY_T[m] + 3);
      chk({resume_next, irq_take, pc_load}, 3'b100);
    end
    osc_mode = rwc_pkg::OSC_RC;
    core.set_gie(1'b1);
    wake_en = 4'h0;
    go_sleep(wc);
    ev(7'h7f);
    quiet(60);
    do_reset(0);
    chk(status_reg[4:3], 2'b10);
    core.set_gie(1'b1);
    wr(3, 8'h01);
    aux_irq_enable = 2'h3;
    idle_select = 1'b1;
    for (int t = 0; t < 3; t++) begin
      go_sleep(wc);
      chk({main_clock_on, slow_clock_on}, 2'b01);
      ev(IEV_T[t]);
      wait_out(100, n);
      chk({irq_take, pc_value}, {1'b1, IVEC_T[t]});
      wr(2, 8'h00);
    end
    idle_select = 1'b0;
    wdt_enable = 1'b1;
    wake_en = 4'hf;
    go_sleep(wc);
    chk(wc, 1'b1);
    ev(7'h1e);
    quiet(60);
    do_reset(1);
    chk(status_reg[4:3], 2'b00);
    wdt_enable = 1'b0;
    core.set_gie(1'b1);
    wr(3, 8'h00);
    ev(7'h04);
    quiet(20);
    wr(2, 8'h00);
    wr(3, 8'h04);
    ev(7'h04);
    wait_out(20, n);
    chk({irq_take, pc_value}, {1'b1, 10'h003});
    chk(int_flag_reg, 8'h04);
    stop_test();
  end
endmodule
